// ==== design/rac_pkg.sv ====
// package for the register access cell bank
package rac_pkg;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned ADDR_W   = 4;
  // register indices, byte address is index times four
  localparam logic [ADDR_W-1:0] IDX_RW     = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_RO     = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_WO     = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_CLR    = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_SET    = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_DB     = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_ACTIVE_VALUE_READBACK = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_ARM    = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_WRS    = 4'h8;
  // implemented bits of the plain read/write register, the rest reserved
  localparam logic [DATA_W-1:0] RW_MASK    = 32'h00FF_FFFF;
  localparam logic [DATA_W-1:0] RST_VAL    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ZERO       = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ARM_BIT    = 32'h0000_0001;
  typedef enum logic [1:0] {
    RAC_IDLE  = 2'b01,
    RAC_ARMED = 2'b10
  } rac_arm_t;
endpackage : rac_pkg

// ==== design/rac_bank.sv ====
// register bank holding one cell of each documented access type
// Behaviour
// - read/write register stores writes, reads them back, drives control output
// - reserved bits ignore writes and read as zero
// - read-only register reads hardware status; writes change nothing
// - write-only register stores and controls hardware; reads return zero
// - clear-type sticky bit set by event, cleared by software writing one
// - set-type sticky bit set by software writing one, cleared by event
// - double-buffered register has two stages, second loads at an update point only while armed
// - reads return first stage; active_value_readback copy exposes second stage
// - arming write commits at next update; controlled write disarms
// - write/read-status register controls hardware, reads status input
`timescale 1ns/1ps
module rac_bank (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rstn,
  // register access
  input  wire logic                          wr_en,
  input  wire logic                          rd_en,
  input  wire logic [rac_pkg::ADDR_W-1:0]    addr,
  input  wire logic [rac_pkg::DATA_W-1:0]    wdata,
  output logic      [rac_pkg::DATA_W-1:0]    rdata,
  // hardware side
  input  wire logic [rac_pkg::DATA_W-1:0]    status_in,
  input  wire logic [rac_pkg::DATA_W-1:0]    wrs_status_in,
  input  wire logic [rac_pkg::DATA_W-1:0]    set_event,
  input  wire logic [rac_pkg::DATA_W-1:0]    clr_event,
  input  wire logic                          update_point,
  output logic      [rac_pkg::DATA_W-1:0]    rw_ctrl,
  output logic      [rac_pkg::DATA_W-1:0]    wo_ctrl,
  output logic      [rac_pkg::DATA_W-1:0]    wrs_ctrl,
  output logic      [rac_pkg::DATA_W-1:0]    db_ctrl,
  output logic      [rac_pkg::DATA_W-1:0]    clr_sticky,
  output logic      [rac_pkg::DATA_W-1:0]    set_sticky,
  output logic                               armed
);
  logic [rac_pkg::DATA_W-1:0] rw_q, wo_q, wrs_q, clr_q, set_q, db1_q, db2_q, rdata_q;
  rac_pkg::rac_arm_t          arm_q;

  function automatic logic hit(input logic [rac_pkg::ADDR_W-1:0] a, input logic [rac_pkg::ADDR_W-1:0] idx);
    hit = (a == idx);
  endfunction : hit

  logic wr_rw, wr_wo, wr_wrs, wr_clr, wr_set, wr_db, wr_arm;
  assign wr_rw  = wr_en && hit(addr, rac_pkg::IDX_RW);
  assign wr_wo  = wr_en && hit(addr, rac_pkg::IDX_WO);
  assign wr_wrs = wr_en && hit(addr, rac_pkg::IDX_WRS);
  assign wr_clr = wr_en && hit(addr, rac_pkg::IDX_CLR);
  assign wr_set = wr_en && hit(addr, rac_pkg::IDX_SET);
  assign wr_db  = wr_en && hit(addr, rac_pkg::IDX_DB);
  // only bit 0 arms, so stray upper bits in an arming write do nothing
  assign wr_arm = wr_en && hit(addr, rac_pkg::IDX_ARM) && ((wdata & rac_pkg::ARM_BIT) != rac_pkg::ZERO);

  // reserved bits are never stored, so they cannot read back
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rw_q <= rac_pkg::RST_VAL;
    end else if (wr_rw) begin
      rw_q <= wdata & rac_pkg::RW_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wo_q  <= rac_pkg::RST_VAL;
      wrs_q <= rac_pkg::RST_VAL;
    end else begin
      if (wr_wo) begin
        wo_q <= wdata;
      end
      if (wr_wrs) begin
        wrs_q <= wdata;
      end
    end
  end

  // event wins over the clearing write so no event is lost
  always_ff @(posedge clk) begin
    if (!rstn) begin
      clr_q <= rac_pkg::RST_VAL;
    end else begin
      clr_q <= (clr_q & ~(wr_clr ? wdata : rac_pkg::ZERO)) | set_event;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      set_q <= rac_pkg::RST_VAL;
    end else begin
      set_q <= (set_q | (wr_set ? wdata : rac_pkg::ZERO)) & ~clr_event;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      db1_q <= rac_pkg::RST_VAL;
    end else if (wr_db) begin
      db1_q <= wdata;
    end
  end

  // a write landing with the update point is not committed by that point
  always_ff @(posedge clk) begin
    if (!rstn) begin
      arm_q <= rac_pkg::RAC_IDLE;
    end else begin
      case (arm_q)
        rac_pkg::RAC_IDLE: begin
          if (wr_arm) begin
            arm_q <= rac_pkg::RAC_ARMED;
          end
        end
        rac_pkg::RAC_ARMED: begin
          if (wr_db) begin
            arm_q <= rac_pkg::RAC_IDLE;
          end else if (update_point) begin
            arm_q <= rac_pkg::RAC_IDLE;
          end
        end
        default: arm_q <= rac_pkg::RAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      db2_q <= rac_pkg::RST_VAL;
    end else if (update_point && arm_q == rac_pkg::RAC_ARMED && !wr_db) begin
      db2_q <= db1_q;
    end
  end

  // one-cycle read latency keeps rdata a flop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_q <= rac_pkg::ZERO;
    end else if (rd_en) begin
      case (addr)
        rac_pkg::IDX_RW:   rdata_q <= rw_q;
        rac_pkg::IDX_RO:   rdata_q <= status_in;
        rac_pkg::IDX_WO:   rdata_q <= rac_pkg::ZERO;
        rac_pkg::IDX_CLR:  rdata_q <= clr_q;
        rac_pkg::IDX_SET:  rdata_q <= set_q;
        rac_pkg::IDX_DB:   rdata_q <= db1_q;
        rac_pkg::IDX_ACTIVE_VALUE_READBACK: rdata_q <= db2_q;
        rac_pkg::IDX_ARM:  rdata_q <= {{(rac_pkg::DATA_W-1){1'b0}}, arm_q == rac_pkg::RAC_ARMED};
        rac_pkg::IDX_WRS:  rdata_q <= wrs_status_in;
        default:           rdata_q <= rac_pkg::ZERO;
      endcase
    end
  end

  assign rdata      = rdata_q;
  assign rw_ctrl    = rw_q;
  assign wo_ctrl    = wo_q;
  assign wrs_ctrl   = wrs_q;
  assign db_ctrl    = db2_q;
  assign clr_sticky = clr_q;
  assign set_sticky = set_q;
  assign armed      = (arm_q == rac_pkg::RAC_ARMED);

  // the reset check has no disable, so it watches the reset itself
  a_rw_store: assert property (@(posedge clk) disable iff (!rstn)
    wr_rw |=> rw_ctrl == ($past(wdata) & rac_pkg::RW_MASK)) else $error("rw store wrong");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (!rstn)
    (rw_ctrl & ~rac_pkg::RW_MASK) == rac_pkg::ZERO) else $error("reserved bit set");
  a_ro_read: assert property (@(posedge clk) disable iff (!rstn)
    rd_en && addr == rac_pkg::IDX_RO |=> rdata == $past(status_in)) else $error("ro read wrong");
  a_wo_zero: assert property (@(posedge clk) disable iff (!rstn)
    rd_en && addr == rac_pkg::IDX_WO |=> rdata == rac_pkg::ZERO) else $error("wo read not zero");
  a_clr_event: assert property (@(posedge clk) disable iff (!rstn)
    set_event != rac_pkg::ZERO |=> (clr_sticky & $past(set_event)) == $past(set_event)) else $error("event lost");
  a_clr_hold: assert property (@(posedge clk) disable iff (!rstn)
    !wr_clr |=> (clr_sticky & $past(clr_sticky)) == $past(clr_sticky)) else $error("sticky dropped");
  a_set_event: assert property (@(posedge clk) disable iff (!rstn)
    clr_event != rac_pkg::ZERO |=> (set_sticky & $past(clr_event)) == rac_pkg::ZERO) else $error("set not cleared");
  a_db_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(update_point && armed) |=> $stable(db_ctrl)) else $error("db moved early");
  a_arm_commit: assert property (@(posedge clk) disable iff (!rstn)
    armed && update_point && !wr_db |=> db_ctrl == $past(db1_q) && !armed) else $error("commit missed");
  a_wrs_ctrl: assert property (@(posedge clk) disable iff (!rstn)
    wr_wrs |=> wrs_ctrl == $past(wdata)) else $error("wrs ctrl wrong");
  a_rw_read: assert property (@(posedge clk) disable iff (!rstn)
    rd_en && addr == rac_pkg::IDX_RW |=> rdata == $past(rw_ctrl)) else $error("rw read wrong");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
    rd_en && addr > rac_pkg::IDX_WRS |=> rdata == rac_pkg::ZERO) else $error("unmapped read not zero");
  a_wo_store: assert property (@(posedge clk) disable iff (!rstn)
    wr_wo |=> wo_ctrl == $past(wdata)) else $error("wo store wrong");
  a_clr_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_clr |=> (clr_sticky & $past(wdata) & ~$past(set_event)) == rac_pkg::ZERO) else $error("clear missed");
  a_clr_zero: assert property (@(posedge clk) disable iff (!rstn)
    wr_clr |=> (clr_sticky & $past(clr_sticky & ~wdata)) == $past(clr_sticky & ~wdata)) else $error("zero cleared");
  a_set_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_set |=> (set_sticky & $past(wdata & ~clr_event)) == $past(wdata & ~clr_event)) else $error("set missed");
  a_set_hold: assert property (@(posedge clk) disable iff (!rstn)
    clr_event == rac_pkg::ZERO |=> (set_sticky & $past(set_sticky)) == $past(set_sticky)) else $error("set dropped");
  a_db_read: assert property (@(posedge clk) disable iff (!rstn)
    rd_en && addr == rac_pkg::IDX_DB |=> rdata == $past(db1_q)) else $error("db read wrong");
  a_readback_read: assert property (@(posedge clk) disable iff (!rstn)
    rd_en && addr == rac_pkg::IDX_ACTIVE_VALUE_READBACK |=> rdata == $past(db_ctrl)) else $error("readback wrong");
  a_arm_entry: assert property (@(posedge clk) disable iff (!rstn)
    !armed && wr_arm |=> armed) else $error("arm missed");
  a_late_disarm: assert property (@(posedge clk) disable iff (!rstn)
    armed && wr_db |=> !armed && $stable(db_ctrl)) else $error("disarm missed");
  a_wrs_read: assert property (@(posedge clk) disable iff (!rstn)
    rd_en && addr == rac_pkg::IDX_WRS |=> rdata == $past(wrs_status_in)) else $error("wrs read wrong");
  a_reset_clear: assert property (@(posedge clk)
    !rstn |=> (rw_ctrl | wo_ctrl | wrs_ctrl | db_ctrl | clr_sticky | set_sticky | rdata) == rac_pkg::ZERO
      && !armed) else $error("reset left state");

  // scenarios the bench must reach
  c_commit: cover property (@(posedge clk) disable iff (!rstn) wr_arm ##[1:20] (armed && update_point));
  c_disarm: cover property (@(posedge clk) disable iff (!rstn) armed && wr_db);
  c_race:   cover property (@(posedge clk) disable iff (!rstn) wr_clr && set_event != rac_pkg::ZERO);
  c_late_write: cover property (@(posedge clk) disable iff (!rstn) armed && update_point && wr_db);
  c_set_race: cover property (@(posedge clk) disable iff (!rstn) wr_set && clr_event != rac_pkg::ZERO);
endmodule : rac_bank

// ==== verification/tb_top.sv ====
// self-checking bench for the register access cell bank
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        update_point = 1'b0;
  logic        armed;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, status_in = 32'h0, wrs_status_in = 32'h0, set_event = 32'h0, clr_event = 32'h0;
  logic [31:0] rdata, rw_ctrl, wo_ctrl, wrs_ctrl, db_ctrl, clr_sticky, set_sticky;
  int          mismatches = 0;
  int          num_checks = 0;
  rac_bank i_rac_bank (.clk(clk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .status_in(status_in), .wrs_status_in(wrs_status_in), .set_event(set_event),
    .clr_event(clr_event), .update_point(update_point), .rw_ctrl(rw_ctrl), .wo_ctrl(wo_ctrl),
    .wrs_ctrl(wrs_ctrl), .db_ctrl(db_ctrl), .clr_sticky(clr_sticky), .set_sticky(set_sticky), .armed(armed));
  initial forever #12.5 clk = ~clk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one cycle of write, update point and events together, so collisions are easy to stage
  task op(input logic w, input logic [3:0] a, input logic [31:0] d, input logic u, input logic [31:0] s,
          input logic [31:0] c);
    @(posedge clk);
    wr_en <= w;
    addr <= a;
    wdata <= d;
    update_point <= u;
    set_event <= s;
    clr_event <= c;
    @(posedge clk);
    wr_en <= 1'b0;
    update_point <= 1'b0;
    set_event <= 32'h0;
    clr_event <= 32'h0;
    @(negedge clk);
  endtask : op
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rd
  task t_reset;
    chk(rw_ctrl | wo_ctrl | wrs_ctrl | db_ctrl | clr_sticky | set_sticky, 32'h0);
    chk(rdata, 32'h0);
    chk({31'h0, armed}, 32'h0);
  endtask : t_reset
  task t_plain;
    op(1'b1, rac_pkg::IDX_RW, 32'hFFFF_FFFF, 1'b0, 32'h0, 32'h0);
    chk(rw_ctrl, rac_pkg::RW_MASK);
    rd(rac_pkg::IDX_RW, rac_pkg::RW_MASK);
    @(posedge clk);
    status_in <= 32'h5A5A_0F0F;
    wrs_status_in <= 32'h0F0F_5A5A;
    op(1'b1, rac_pkg::IDX_RO, 32'h1234_5678, 1'b0, 32'h0, 32'h0);
    chk(rw_ctrl, rac_pkg::RW_MASK);
    chk(wo_ctrl | wrs_ctrl | db_ctrl, 32'h0);
    rd(rac_pkg::IDX_RO, 32'h5A5A_0F0F);
    @(posedge clk);
    status_in <= 32'hA5A5_F0F0;
    rd(rac_pkg::IDX_RO, 32'hA5A5_F0F0);
    rd(4'hF, 32'h0);
    op(1'b1, rac_pkg::IDX_WO, 32'hC3C3_3C3C, 1'b0, 32'h0, 32'h0);
    chk(wo_ctrl, 32'hC3C3_3C3C);
    rd(rac_pkg::IDX_WO, 32'h0);
    op(1'b1, rac_pkg::IDX_WRS, 32'h8765_4321, 1'b0, 32'h0, 32'h0);
    chk(wrs_ctrl, 32'h8765_4321);
    rd(rac_pkg::IDX_WRS, 32'h0F0F_5A5A);
  endtask : t_plain
  // read-modify-write: read bits go back as read, bits 7:6 stand for must_be_zero
  task t_preserve;
    logic [31:0] v;
    rd(rac_pkg::IDX_RW, rac_pkg::RW_MASK);
    v = rdata;
    op(1'b1, rac_pkg::IDX_RW, (v & 32'hFFFF_FF00) | 32'h0000_0012, 1'b0, 32'h0, 32'h0);
    chk(rw_ctrl, 32'h00FF_FF12);
  endtask : t_preserve
  task t_sticky;
    op(1'b0, 4'h0, 32'h0, 1'b0, 32'h0000_0011, 32'h0);
    chk(clr_sticky, 32'h0000_0011);
    op(1'b1, rac_pkg::IDX_CLR, 32'h0, 1'b0, 32'h0, 32'h0);
    rd(rac_pkg::IDX_CLR, 32'h0000_0011);
    op(1'b1, rac_pkg::IDX_CLR, 32'h0000_0001, 1'b0, 32'h0, 32'h0);
    chk(clr_sticky, 32'h0000_0010);
    op(1'b1, rac_pkg::IDX_CLR, 32'h0000_0001, 1'b0, 32'h0000_0001, 32'h0);
    chk(clr_sticky, 32'h0000_0011);
    op(1'b1, rac_pkg::IDX_SET, 32'h0000_0003, 1'b0, 32'h0, 32'h0);
    chk(set_sticky, 32'h0000_0003);
    op(1'b1, rac_pkg::IDX_SET, 32'h0, 1'b0, 32'h0, 32'h0);
    rd(rac_pkg::IDX_SET, 32'h0000_0003);
    op(1'b0, 4'h0, 32'h0, 1'b0, 32'h0, 32'h0000_0001);
    chk(set_sticky, 32'h0000_0002);
    op(1'b1, rac_pkg::IDX_SET, 32'h0000_0001, 1'b0, 32'h0, 32'h0000_0001);
    chk(set_sticky, 32'h0000_0002);
  endtask : t_sticky
  task t_dbuf;
    op(1'b1, rac_pkg::IDX_DB, 32'hA1A1_0001, 1'b1, 32'h0, 32'h0);
    chk(db_ctrl, 32'h0);
    rd(rac_pkg::IDX_DB, 32'hA1A1_0001);
    op(1'b1, rac_pkg::IDX_ARM, rac_pkg::ARM_BIT, 1'b0, 32'h0, 32'h0);
    chk({31'h0, armed}, 32'h1);
    op(1'b0, 4'h0, 32'h0, 1'b1, 32'h0, 32'h0);
    chk(db_ctrl, 32'hA1A1_0001);
    chk({31'h0, armed}, 32'h0);
    rd(rac_pkg::IDX_ACTIVE_VALUE_READBACK, 32'hA1A1_0001);
    op(1'b1, rac_pkg::IDX_ARM, rac_pkg::ARM_BIT, 1'b0, 32'h0, 32'h0);
    rd(rac_pkg::IDX_ARM, 32'h1);
    op(1'b1, rac_pkg::IDX_DB, 32'hB2B2_0002, 1'b0, 32'h0, 32'h0);
    chk({31'h0, armed}, 32'h0);
    op(1'b0, 4'h0, 32'h0, 1'b1, 32'h0, 32'h0);
    chk(db_ctrl, 32'hA1A1_0001);
    rd(rac_pkg::IDX_DB, 32'hB2B2_0002);
    // a controlled write landing with the update point disarms and commits nothing
    op(1'b1, rac_pkg::IDX_ARM, rac_pkg::ARM_BIT, 1'b0, 32'h0, 32'h0);
    op(1'b1, rac_pkg::IDX_DB, 32'hC3C3_0003, 1'b1, 32'h0, 32'h0);
    chk(db_ctrl, 32'hA1A1_0001);
    chk({31'h0, armed}, 32'h0);
    op(1'b1, rac_pkg::IDX_ARM, rac_pkg::ARM_BIT, 1'b0, 32'h0, 32'h0);
    op(1'b0, 4'h0, 32'h0, 1'b1, 32'h0, 32'h0);
    chk(db_ctrl, 32'hC3C3_0003);
    rd(rac_pkg::IDX_ACTIVE_VALUE_READBACK, 32'hC3C3_0003);
  endtask : t_dbuf
  // reset in mid-run must bring the second stage, every sticky bit and the arming back
  task t_midreset;
    op(1'b1, rac_pkg::IDX_ARM, rac_pkg::ARM_BIT, 1'b0, 32'h0, 32'h0);
    chk({31'h0, armed}, 32'h1);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    t_reset;
    op(1'b1, rac_pkg::IDX_RW, 32'h0000_00A5, 1'b0, 32'h0, 32'h0);
    chk(rw_ctrl, 32'h0000_00A5);
  endtask : t_midreset
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  // about 90 cycles are needed; the limit leaves ample slack
  initial begin
    #50000;
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    t_reset;
    t_plain;
    t_preserve;
    t_sticky;
    t_dbuf;
    t_midreset;
    stop_test;
  end
endmodule : tb_top
